// ### design/vrs_pkg.sv
// package: register map, field layout, reset values and carrier type of the view resizer scale select
package vrs_pkg;
    // ----------------------------------------------------------------
    // register indices and byte addresses (byte address = 4 * index)
    // ----------------------------------------------------------------
    localparam logic [31:0] VRS_IDX_CTRL = 32'h0000_2440;
    localparam logic [31:0] VRS_IDX_RATE = 32'h0000_244C;
    localparam logic [31:0] VRS_IDX_MODE = 32'h0000_244E;
    localparam logic [31:0] VRS_IDX_STAT = 32'h0000_2450;
    localparam logic [31:0] VRS_ADDR_CTRL = VRS_IDX_CTRL << 2;
    localparam logic [31:0] VRS_ADDR_RATE = VRS_IDX_RATE << 2;
    localparam logic [31:0] VRS_ADDR_MODE = VRS_IDX_MODE << 2;
    localparam logic [31:0] VRS_ADDR_STAT = VRS_IDX_STAT << 2;
    // ----------------------------------------------------------------
    // fields
    // ----------------------------------------------------------------
    localparam int VRS_CTRL_INDEP_BIT = 2;
    localparam int VRS_RATE_H_LSB = 0;
    localparam int VRS_RATE_V_LSB = 8;
    localparam int VRS_STAT_LEGAL_BIT = 16;
    localparam int VRS_STAT_ACTIVE_BIT = 17;
    localparam logic [1:0] VRS_MODE_NONE = 2'h0;
    localparam logic [1:0] VRS_MODE_REDUCE = 2'h1;
    localparam logic [1:0] VRS_MODE_AVERAGE = 2'h2;
    localparam logic [1:0] VRS_MODE_RSVD = 2'h3;
    localparam logic [7:0] VRS_RATE_UNITY = 8'h80;
    localparam logic [2:0] VRS_HSIZE_WORD = 3'h2;
    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [15:0] VRS_RST_CTRL = 16'h0000;
    localparam logic [15:0] VRS_RST_RATE = 16'h8080;
    localparam logic [1:0] VRS_RST_MODE = 2'h0;
    // ----------------------------------------------------------------
    // carrier
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [1:0] mode;
        logic active;
        logic legal;
        logic [7:0] vNum;
        logic [7:0] hNum;
    } vrs_scale_t;
endpackage

// ### design/vrs_rate_check.sv
// rate code legality check for one scaling direction
`timescale 1ns/1ps
`default_nettype none
module vrs_rate_check #(
    parameter bit POW2_IN_AVG = 1'b1
) (
    input wire logic [7:0] code,
    input wire logic [1:0] mode,
    output logic legal
);
    import vrs_pkg::*;
    logic inRange;
    logic pow2;
    always_comb begin
        inRange = (code != 8'h00) && (code <= VRS_RATE_UNITY);
        pow2 = (code & (code - 8'h01)) == 8'h00;
        case (mode)
            VRS_MODE_REDUCE: legal = inRange;
            VRS_MODE_AVERAGE: legal = inRange && (!POW2_IN_AVG || pow2);
            default: legal = 1'b0;
        endcase
    end
endmodule
`default_nettype wire

// ### design/vrs_scale_select.sv
// view resizer scale select: ahb-lite register slave and scale factor decode
// Operation
// - independent bit set: low rate byte is the horizontal factor only
// - independent bit clear: low rate byte drives both directions, high byte ignored
// - reduce mode: horizontal code N in 1..128 gives N/128; zero always reserved
// - mode 00 none, 01 reduce both, 10 reduce v average h, 11 reserved
// - independent scaling takes the vertical factor from the high rate byte
// - vertical code N in 1..128 gives N/128 in both reduce and averaging modes
`timescale 1ns/1ps
`default_nettype none
module vrs_scale_select (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic clkEn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output vrs_pkg::vrs_scale_t scale
);
    import vrs_pkg::*;

    // ----------------------------------------------------------------
    // bus slave
    // ----------------------------------------------------------------
    logic [15:0] ctrl, next_ctrl;
    logic [15:0] rate, next_rate;
    logic [1:0] mode, next_mode;
    logic dpWrite, next_dpWrite;
    logic dpRead, next_dpRead;
    logic [31:0] dpAddr, next_dpAddr;
    logic [31:0] next_hrdata;
    logic addrValid;
    vrs_scale_t next_scale;

    function automatic logic [31:0] readMux(input logic [31:0] a, input logic [15:0] c,
                                            input logic [15:0] r, input logic [1:0] m,
                                            input vrs_scale_t s);
        logic [31:0] d;
        d = 32'h0000_0000;
        case (a)
            VRS_ADDR_CTRL: d = {16'h0000, c};
            VRS_ADDR_RATE: d = {16'h0000, r};
            VRS_ADDR_MODE: d = {30'h0000_0000, m};
            VRS_ADDR_STAT: d = {14'h0000, s.active, s.legal, s.vNum, s.hNum};
            default: d = 32'h0000_0000;
        endcase
        return d;
    endfunction

    always_comb begin
        addrValid = hsel && htrans[1] && hready;
        next_ctrl = ctrl;
        next_rate = rate;
        next_mode = mode;
        next_dpWrite = addrValid && hwrite && (hsize == VRS_HSIZE_WORD);
        next_dpRead = addrValid && !hwrite;
        next_dpAddr = addrValid ? haddr : dpAddr;
        if (dpWrite) begin
            case (dpAddr)
                VRS_ADDR_CTRL: next_ctrl = hwdata[15:0];
                VRS_ADDR_RATE: next_rate = hwdata[15:0];
                VRS_ADDR_MODE: next_mode = hwdata[1:0];
                default: next_ctrl = ctrl;
            endcase
        end
        // forward a write in its data phase to a read address phase in the same cycle
        next_hrdata = next_dpRead ? readMux(haddr, next_ctrl, next_rate, next_mode, scale) : 32'h0000_0000;
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl <= VRS_RST_CTRL;
            rate <= VRS_RST_RATE;
            mode <= VRS_RST_MODE;
            dpWrite <= 1'b0;
            dpRead <= 1'b0;
            dpAddr <= 32'h0000_0000;
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else if (clkEn) begin
            ctrl <= next_ctrl;
            rate <= next_rate;
            mode <= next_mode;
            dpWrite <= next_dpWrite;
            dpRead <= next_dpRead;
            dpAddr <= next_dpAddr;
            hrdata <= next_hrdata;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // scale decode
    // ----------------------------------------------------------------
    logic indep;
    logic [7:0] dirCode [2];
    logic dirLegal [2];

    always_comb begin
        indep = ctrl[VRS_CTRL_INDEP_BIT];
        dirCode[0] = rate[VRS_RATE_H_LSB +: 8];
        dirCode[1] = indep ? rate[VRS_RATE_V_LSB +: 8] : rate[VRS_RATE_H_LSB +: 8];
    end

    // horizontal allows only powers of two when averaging; vertical takes any 1..128
    for (genvar g = 0; g < 2; g++) begin : gDir
        vrs_rate_check #(
            .POW2_IN_AVG(g == 0)
        ) uCheck (
            .code(dirCode[g]),
            .mode(mode),
            .legal(dirLegal[g])
        );
    end

    always_comb begin
        next_scale.mode = mode;
        next_scale.active = (mode == VRS_MODE_REDUCE) || (mode == VRS_MODE_AVERAGE);
        // no-scale mode is always a legal setting; reserved mode never is
        next_scale.legal = (mode == VRS_MODE_NONE) || (next_scale.active && dirLegal[0] && dirLegal[1]);
        // unity factor whenever scaling is off or the setting is illegal, so nothing odd leaks out
        next_scale.hNum = (next_scale.active && next_scale.legal) ? dirCode[0] : VRS_RATE_UNITY;
        next_scale.vNum = (next_scale.active && next_scale.legal) ? dirCode[1] : VRS_RATE_UNITY;
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            scale <= '{mode: VRS_RST_MODE, active: 1'b0, legal: 1'b1, vNum: VRS_RATE_UNITY, hNum: VRS_RATE_UNITY};
        end else if (clkEn) begin
            scale <= next_scale;
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    indep_horiz_a: assert property (@(posedge clock) disable iff (sys_rst)
        clkEn && indep && next_scale.active && next_scale.legal |=> scale.hNum == $past(rate[7:0]))
        else $error("horizontal factor not from low rate byte");
    shared_rate_a: assert property (@(posedge clock) disable iff (sys_rst)
        clkEn && !indep |=> scale.vNum == scale.hNum)
        else $error("shared rate gives different factors");
    reduce_code_a: assert property (@(posedge clock) disable iff (sys_rst)
        clkEn && mode == VRS_MODE_REDUCE && !indep && rate[7:0] != 8'h00 && rate[7:0] <= 8'h80
        |=> scale.legal && scale.hNum == $past(rate[7:0]))
        else $error("reduce mode code not applied");
    zero_reserved_a: assert property (@(posedge clock) disable iff (sys_rst)
        clkEn && mode != VRS_MODE_NONE && (dirCode[0] == 8'h00 || dirCode[1] == 8'h00)
        |=> !scale.legal && scale.hNum == VRS_RATE_UNITY && scale.vNum == VRS_RATE_UNITY)
        else $error("zero rate code accepted");
    mode_decode_a: assert property (@(posedge clock) disable iff (sys_rst)
        clkEn && mode == VRS_MODE_RSVD |=> scale.mode == VRS_MODE_RSVD && !scale.active && !scale.legal)
        else $error("reserved mode decoded as active");
    mode_bits_a: assert property (@(posedge clock) disable iff (sys_rst)
        dpRead && dpAddr == VRS_ADDR_MODE |-> hrdata[31:2] == 30'h0000_0000 && hrdata[1:0] == $past(next_mode))
        else $error("mode register read wrong");
    vert_byte_a: assert property (@(posedge clock) disable iff (sys_rst)
        clkEn && indep && next_scale.legal && next_scale.active |=> scale.vNum == $past(rate[15:8]))
        else $error("vertical factor not from high rate byte");
    vert_avg_a: assert property (@(posedge clock) disable iff (sys_rst)
        clkEn && mode == VRS_MODE_AVERAGE && indep && rate[7:0] == 8'h01 && rate[15:8] == 8'h03
        |=> scale.legal && scale.vNum == 8'h03)
        else $error("vertical odd code refused in averaging mode");

    // ----------------------------------------------------------------
    // decode limits and freeze
    // ----------------------------------------------------------------
    mode_none_a: assert property (@(posedge clock) disable iff (sys_rst)
        clkEn && mode == VRS_MODE_NONE
        |=> scale.legal && !scale.active && scale.hNum == VRS_RATE_UNITY && scale.vNum == VRS_RATE_UNITY)
        else $error("no-scale mode not passed as unity");

    // refused here so that a bad horizontal code never reaches the averaging datapath
    avg_pow2_a: assert property (@(posedge clock) disable iff (sys_rst)
        clkEn && mode == VRS_MODE_AVERAGE && $countones(dirCode[0]) > 1
        |=> !scale.legal && scale.hNum == VRS_RATE_UNITY)
        else $error("odd horizontal code accepted while averaging");

    above_unity_a: assert property (@(posedge clock) disable iff (sys_rst)
        clkEn && mode == VRS_MODE_REDUCE && dirCode[0] > VRS_RATE_UNITY |=> !scale.legal)
        else $error("code above unity accepted");

    vert_reduce_a: assert property (@(posedge clock) disable iff (sys_rst)
        clkEn && mode == VRS_MODE_REDUCE && indep && dirCode[0] != 8'h00 && dirCode[0] <= VRS_RATE_UNITY
        && rate[15:8] != 8'h00 && rate[15:8] <= VRS_RATE_UNITY |=> scale.legal && scale.vNum == $past(rate[15:8]))
        else $error("vertical code not applied in reduce mode");

    mode_upper_a: assert property (@(posedge clock) disable iff (sys_rst)
        clkEn && dpWrite && dpAddr == VRS_ADDR_MODE |=> mode == $past(hwdata[1:0]))
        else $error("mode write took the wrong bits");

    // clock enable low must hold registers, bus pipeline and outputs alike
    freeze_hold_a: assert property (@(posedge clock) disable iff (sys_rst)
        !clkEn |=> $stable(scale) && $stable(mode) && $stable(rate) && $stable(hrdata))
        else $error("state moved while clock enable low");

    // ----------------------------------------------------------------
    // covers
    // ----------------------------------------------------------------
    reduce_seen_c: cover property (@(posedge clock) disable iff (sys_rst)
        scale.active && scale.legal && scale.mode == VRS_MODE_REDUCE);
    avg_seen_c: cover property (@(posedge clock) disable iff (sys_rst)
        scale.active && scale.legal && scale.mode == VRS_MODE_AVERAGE && scale.vNum != scale.hNum);
    illegal_seen_c: cover property (@(posedge clock) disable iff (sys_rst)
        scale.active && !scale.legal);
    rsvd_seen_c: cover property (@(posedge clock) disable iff (sys_rst)
        scale.mode == VRS_MODE_RSVD && !scale.legal);
    frozen_seen_c: cover property (@(posedge clock) disable iff (sys_rst)
        !clkEn && scale.active);
endmodule
`default_nettype wire

// ### test/vrs_scale_select_tb.sv
// testbench: register access and scale factor decode of the view resizer scale select
`timescale 1ns/1ps
`default_nettype none
`define CHK(what, exp, got) begin nCompared++; if ((got) !== (exp)) begin errCount++; \
    $display("[FAIL] %s expected %h seen %h", what, exp, got); end end
module vrs_scale_select_tb;
    import vrs_pkg::*;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic clock, sys_rst, clkEn, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rdData;
    logic [1:0] htrans;
    logic [2:0] hsize;
    vrs_scale_t scale;
    int errCount = 0;
    int nCompared = 0;
    int cycles = 0;

    vrs_scale_select DUT (.clock(clock), .sys_rst(sys_rst), .clkEn(clkEn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .scale(scale));

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    // ------------------------------------------------------------
    // closing report and hang guard
    // ------------------------------------------------------------
    task automatic wrapUp;
        if (errCount == 0 && nCompared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            errCount++;
            wrapUp();
        end
    end
    // ------------------------------------------------------------
    // bus master and expectation
    // ------------------------------------------------------------
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd, input logic [2:0] sz);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        hsize <= sz;
        @(posedge clock);
        while (hreadyout !== 1'b1) @(posedge clock);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge clock);
        while (hreadyout !== 1'b1) @(posedge clock);
        rdData = hrdata;
        `CHK("hresp", 1'b0, hresp)
    endtask

    // unity factors whenever the setting is inactive or illegal
    function automatic vrs_scale_t expScale(logic [1:0] m, logic [15:0] r, logic ind);
        logic [7:0] h, v;
        vrs_scale_t s;
        h = r[7:0];
        v = ind ? r[15:8] : r[7:0];
        s.mode = m;
        s.active = (m == 2'h1) || (m == 2'h2);
        s.legal = (m == 2'h0) || (s.active && h != 0 && v != 0 && h <= 128 && v <= 128
            && (m == 2'h1 || $countones(h) == 1));
        s.hNum = (s.active && s.legal) ? h : 8'h80;
        s.vNum = (s.active && s.legal) ? v : 8'h80;
        return s;
    endfunction

    task automatic setCfg(input logic ind, input logic [15:0] r, input logic [1:0] m);
        vrs_scale_t e;
        e = expScale(m, r, ind);
        ahb(1'b1, VRS_ADDR_CTRL, {29'h0, ind, 2'h0}, VRS_HSIZE_WORD);
        ahb(1'b1, VRS_ADDR_RATE, {16'h0, r}, VRS_HSIZE_WORD);
        ahb(1'b1, VRS_ADDR_MODE, {30'h0, m}, VRS_HSIZE_WORD);
        repeat (2) @(posedge clock);
        `CHK("scale", e, scale)
        ahb(1'b0, VRS_ADDR_STAT, 32'h0, VRS_HSIZE_WORD);
        `CHK("status", {14'h0, e.active, e.legal, e.vNum, e.hNum}, rdData)
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic testReset;
        `CHK("scale", {2'h0, 1'b0, 1'b1, 8'h80, 8'h80}, scale)
        ahb(1'b0, VRS_ADDR_RATE, 32'h0, VRS_HSIZE_WORD);
        `CHK("rate", 32'h0000_8080, rdData)
        ahb(1'b0, VRS_ADDR_MODE, 32'h0, VRS_HSIZE_WORD);
        `CHK("mode", 32'h0, rdData)
    endtask

    task automatic testModes;
        logic [7:0] codes [6] = '{8'h00, 8'h01, 8'h03, 8'h7F, 8'h80, 8'h81};
        for (int m = 0; m < 4; m++) setCfg(1'b0, 16'h0003, m[1:0]);
        foreach (codes[i]) setCfg(1'b0, {8'h55, codes[i]}, 2'h1);
    endtask

    task automatic testAverage;
        for (int i = 0; i < 8; i++) setCfg(1'b1, {8'h03, 8'h01 << i}, 2'h2);
        setCfg(1'b1, 16'h7F41, 2'h2);
        setCfg(1'b1, 16'h0010, 2'h2);
        setCfg(1'b0, 16'h0006, 2'h2);
    endtask

    task automatic testIndep;
        setCfg(1'b1, 16'h2205, 2'h1);
        setCfg(1'b1, 16'h0005, 2'h1);
        setCfg(1'b0, 16'h0005, 2'h1);
    endtask

    task automatic testRegs;
        setCfg(1'b0, 16'h4040, 2'h1);
        // byte-wide writes must leave the stored rate alone
        ahb(1'b1, VRS_ADDR_RATE, 32'h0000_1111, 3'h0);
        ahb(1'b0, VRS_ADDR_RATE, 32'h0, VRS_HSIZE_WORD);
        `CHK("rate", 32'h0000_4040, rdData)
        ahb(1'b1, VRS_ADDR_MODE, 32'hFFFF_FFFE, VRS_HSIZE_WORD);
        ahb(1'b0, VRS_ADDR_MODE, 32'h0, VRS_HSIZE_WORD);
        `CHK("mode", 32'h0000_0002, rdData)
        ahb(1'b1, VRS_ADDR_RATE + 32'h4, 32'hFFFF_FFFF, VRS_HSIZE_WORD);
        ahb(1'b0, VRS_ADDR_RATE + 32'h4, 32'h0, VRS_HSIZE_WORD);
        `CHK("unmapped", 32'h0, rdData)
    endtask

    task automatic testFreeze;
        setCfg(1'b1, 16'h8080, 2'h1);
        clkEn <= 1'b0;
        ahb(1'b1, VRS_ADDR_RATE, 32'h0000_0303, VRS_HSIZE_WORD);
        repeat (2) @(posedge clock);
        `CHK("frozen scale", expScale(2'h1, 16'h8080, 1'b1), scale)
        clkEn <= 1'b1;
        ahb(1'b0, VRS_ADDR_RATE, 32'h0, VRS_HSIZE_WORD);
        `CHK("frozen rate", 32'h0000_8080, rdData)
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        sys_rst = 1'b1;
        clkEn = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = VRS_HSIZE_WORD;
        hwdata = 32'h0;
        repeat (3) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        testReset();
        testModes();
        testAverage();
        testIndep();
        testRegs();
        testFreeze();
        sys_rst <= 1'b1;
        @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        testReset();
        wrapUp();
    end
endmodule
`default_nettype wire
